// ---- rtl/pdcr_defines.vh ----
// Purpose: constants for the synthesizer divider control register bank
// Assumes: 8-bit register port, 8-bit address
// Notes:   offsets are byte addresses on the plain register port
`ifndef PDCR_DEFINES_VH
`define PDCR_DEFINES_VH

// ****************************************
// register offsets
// ****************************************
`define PDCR_ADDR_FB_BYPASS      8'h03
`define PDCR_ADDR_FB_PHASE       8'h05
`define PDCR_ADDR_REF_PHASE      8'h06
`define PDCR_ADDR_FS_BYPASS      8'h0A
`define PDCR_ADDR_PREDIV         8'h0C
`define PDCR_ADDR_PUMP           8'h10
`define PDCR_ADDR_OFFSET         8'h11
`define PDCR_ADDR_AMP_PUMP       8'h12
`define PDCR_ADDR_STATUS         8'h13

// ****************************************
// field positions
// ****************************************
`define PDCR_BIT_FB_PD           7
`define PDCR_BIT_FB_CHAIN        0
`define PDCR_BIT_FS_BYPASS       0
`define PDCR_BIT_DOUBLER         7
`define PDCR_BIT_POLARITY        7
`define PDCR_BIT_FORCE_MID       6

// ****************************************
// reset values
// ****************************************
`define PDCR_RST_PUMP_CODE       5'h18
`define PDCR_RST_FORCE_MID       1'h1
`define PDCR_RST_PHASE           3'h0
`define PDCR_RST_PREDIV          6'h00
`define PDCR_RST_PUMP_UA         11'h4E2
`define PDCR_RST_PUMP2_CODE      5'h18

// ****************************************
// charge pump scale
// ****************************************
`define PDCR_PUMP_STEP_UA        11'h032
`define PDCR_PUMP_UA_W           11

`endif

// ---- rtl/pdcr_prediv.v ----
// Purpose: second-stage input frequency selection
// Assumes: single register clock
// Notes:   derives divide ratio and path select
`timescale 1ns/1ps
`include "pdcr_defines.vh"

module pdcr_prediv (
    input  wire       clk_i,
    input  wire       rst_i,
    input  wire       ce_i,
    input  wire [5:0] prediv_i,
    input  wire       doubler_i,
    output reg        bypass_o,
    output reg        double_o,
    output reg  [5:0] ratio_o
);

    // ****************************************
    // path select
    // ****************************************
    always @(posedge clk_i) begin
        if (rst_i) begin
            bypass_o <= 1'h1;
            double_o <= 1'h0;
            ratio_o  <= 6'h01;
        end else if (ce_i) begin
            double_o <= doubler_i;
            if (doubler_i) begin
                bypass_o <= 1'h1;
                ratio_o  <= 6'h01;
            end else if (prediv_i == 6'h00) begin
                bypass_o <= 1'h1;
                ratio_o  <= 6'h01;
            end else begin
                bypass_o <= 1'h0;
                ratio_o  <= prediv_i;
            end
        end
    end

endmodule

// ---- rtl/pdcr_regs.v ----
// Purpose: synthesizer divider and loop control register bank
// Assumes: plain register port, read data one cycle after strobe
// Notes:   control outputs are registered from fields, some inverted, scaled or decoded
//
// Chosen here: the plain strobed port.
`timescale 1ns/1ps
`include "pdcr_defines.vh"

module pdcr_regs (
    input  wire        CLOCK_I,
    input  wire        SYS_RST_I,
    input  wire        CE_I,
    input  wire [7:0]  ADDR_I,
    input  wire [7:0]  WDATA_I,
    input  wire        WR_I,
    input  wire        RD_I,
    output reg  [7:0]  RDATA_O,
    output reg         SECOND_FB_DIVIDER_EN_O,
    output reg         FB_CHAIN_PRODUCT_O,
    output reg  [5:0]  LOCK_WINDOW_PHASE_O,
    output reg         FIRST_STAGE_LOOP_EN_O,
    output reg         FIRST_STAGE_ROUTE_AROUND_O,
    output reg         OSC_TUNING_NEGATIVE_O,
    output reg         TUNING_PIN_MID_O,
    output reg         FIRST_STAGE_FORCE_UNLOCK_O,
    output reg  [10:0] FIRST_STAGE_PUMP_UA_O,
    output reg         PREDIV_BYPASS_O,
    output reg         DOUBLER_ACTIVE_O,
    output reg  [5:0]  PREDIV_RATIO_O,
    output reg  [4:0]  SECOND_STAGE_PUMP_CURRENT_O,
    output reg  [1:0]  OSC_OUTPUT_AMPLITUDE_O,
    output reg         OSC_OUTPUT_POWER_ON_O,
    output reg         OSC_OUTPUT_FORMAT_O,
    output reg         PHASE_OFFSET_ENABLE_O,
    output reg  [4:0]  PHASE_OFFSET_O
);

    // ****************************************
    // register fields
    // ****************************************
    reg        second_fb_divider_powerdown_r;
    reg        feedback_chain_select_r;
    reg [2:0]  fb_divider_phase_r;
    reg [2:0]  ref_divider_phase_r;
    reg        first_stage_bypass_r;
    reg        doubler_select_r;
    reg [5:0]  synth_input_predivider_r;
    reg        osc_tuning_polarity_r;
    reg        force_mid_tuning_r;
    reg [4:0]  first_stage_pump_current_r;
    reg        osc_output_power_on_r;
    reg        osc_output_format_r;
    reg        phase_offset_enable_r;
    reg [4:0]  phase_offset_r;
    reg [1:0]  osc_output_amplitude_r;
    reg [4:0]  second_stage_pump_current_r;
    reg [7:0]  rdata_nxt;
    wire       pd_bypass;
    wire       pd_double;
    wire [5:0] pd_ratio;
    wire [10:0] pump_ua;

    // ****************************************
    // register writes
    // ****************************************
    always @(posedge CLOCK_I) begin
        if (SYS_RST_I) begin
            second_fb_divider_powerdown_r <= 1'h0;
            feedback_chain_select_r       <= 1'h0;
            fb_divider_phase_r            <= `PDCR_RST_PHASE;
            ref_divider_phase_r           <= `PDCR_RST_PHASE;
            first_stage_bypass_r          <= 1'h0;
            doubler_select_r              <= 1'h0;
            synth_input_predivider_r      <= `PDCR_RST_PREDIV;
            osc_tuning_polarity_r         <= 1'h0;
            force_mid_tuning_r            <= `PDCR_RST_FORCE_MID;
            first_stage_pump_current_r    <= `PDCR_RST_PUMP_CODE;
            osc_output_power_on_r         <= 1'h0;
            osc_output_format_r           <= 1'h0;
            phase_offset_enable_r         <= 1'h0;
            phase_offset_r                <= 5'h00;
            osc_output_amplitude_r        <= 2'h0;
            second_stage_pump_current_r   <= `PDCR_RST_PUMP2_CODE;
        end else if (CE_I && WR_I) begin
            case (ADDR_I)
                `PDCR_ADDR_FB_BYPASS: begin
                    second_fb_divider_powerdown_r <= WDATA_I[`PDCR_BIT_FB_PD];
                    feedback_chain_select_r       <= WDATA_I[`PDCR_BIT_FB_CHAIN];
                end
                `PDCR_ADDR_FB_PHASE: begin
                    fb_divider_phase_r <= WDATA_I[2:0];
                end
                `PDCR_ADDR_REF_PHASE: begin
                    ref_divider_phase_r <= WDATA_I[2:0];
                end
                `PDCR_ADDR_FS_BYPASS: begin
                    first_stage_bypass_r <= WDATA_I[`PDCR_BIT_FS_BYPASS];
                end
                `PDCR_ADDR_PREDIV: begin
                    doubler_select_r         <= WDATA_I[`PDCR_BIT_DOUBLER];
                    synth_input_predivider_r <= WDATA_I[5:0];
                end
                `PDCR_ADDR_PUMP: begin
                    osc_tuning_polarity_r      <= WDATA_I[`PDCR_BIT_POLARITY];
                    force_mid_tuning_r         <= WDATA_I[`PDCR_BIT_FORCE_MID];
                    first_stage_pump_current_r <= WDATA_I[4:0];
                end
                `PDCR_ADDR_OFFSET: begin
                    osc_output_power_on_r <= WDATA_I[7];
                    osc_output_format_r   <= WDATA_I[6];
                    phase_offset_enable_r <= WDATA_I[5];
                    phase_offset_r        <= WDATA_I[4:0];
                end
                `PDCR_ADDR_AMP_PUMP: begin
                    osc_output_amplitude_r      <= WDATA_I[6:5];
                    second_stage_pump_current_r <= WDATA_I[4:0];
                end
                default: begin
                end
            endcase
        end
    end

    // ****************************************
    // read mux
    // ****************************************
    always @* begin
        rdata_nxt = 8'h00;
        case (ADDR_I)
            `PDCR_ADDR_FB_BYPASS:
                rdata_nxt = {second_fb_divider_powerdown_r, 6'h00, feedback_chain_select_r};
            `PDCR_ADDR_FB_PHASE:
                rdata_nxt = {5'h00, fb_divider_phase_r};
            `PDCR_ADDR_REF_PHASE:
                rdata_nxt = {5'h00, ref_divider_phase_r};
            `PDCR_ADDR_FS_BYPASS:
                rdata_nxt = {7'h00, first_stage_bypass_r};
            `PDCR_ADDR_PREDIV:
                rdata_nxt = {doubler_select_r, 1'h0, synth_input_predivider_r};
            `PDCR_ADDR_PUMP:
                rdata_nxt = {osc_tuning_polarity_r, force_mid_tuning_r, 1'h0, first_stage_pump_current_r};
            `PDCR_ADDR_OFFSET:
                rdata_nxt = {osc_output_power_on_r, osc_output_format_r, phase_offset_enable_r, phase_offset_r};
            `PDCR_ADDR_AMP_PUMP:
                rdata_nxt = {1'h0, osc_output_amplitude_r, second_stage_pump_current_r};
            `PDCR_ADDR_STATUS:
                rdata_nxt = {4'h0, PREDIV_BYPASS_O, DOUBLER_ACTIVE_O, FIRST_STAGE_FORCE_UNLOCK_O,
                             SECOND_FB_DIVIDER_EN_O};
            default:
                rdata_nxt = 8'h00;
        endcase
    end

    always @(posedge CLOCK_I) begin
        if (SYS_RST_I) begin
            RDATA_O <= 8'h00;
        end else if (CE_I) begin
            RDATA_O <= RD_I ? rdata_nxt : 8'h00;
        end
    end

    // ****************************************
    // second stage input path
    // ****************************************
    pdcr_prediv u_prediv (
        .clk_i     (CLOCK_I),
        .rst_i     (SYS_RST_I),
        .ce_i      (CE_I),
        .prediv_i  (synth_input_predivider_r),
        .doubler_i (doubler_select_r),
        .bypass_o  (pd_bypass),
        .double_o  (pd_double),
        .ratio_o   (pd_ratio)
    );

    // pump current in microamps
    assign pump_ua = ({6'h00, first_stage_pump_current_r} + 11'h001) * `PDCR_PUMP_STEP_UA;

    // ****************************************
    // control outputs
    // ****************************************
    always @(posedge CLOCK_I) begin
        if (SYS_RST_I) begin
            SECOND_FB_DIVIDER_EN_O      <= 1'h1;
            FB_CHAIN_PRODUCT_O          <= 1'h0;
            LOCK_WINDOW_PHASE_O         <= 6'h00;
            FIRST_STAGE_LOOP_EN_O       <= 1'h1;
            FIRST_STAGE_ROUTE_AROUND_O  <= 1'h0;
            OSC_TUNING_NEGATIVE_O       <= 1'h0;
            TUNING_PIN_MID_O            <= 1'h1;
            FIRST_STAGE_FORCE_UNLOCK_O  <= 1'h1;
            FIRST_STAGE_PUMP_UA_O       <= `PDCR_RST_PUMP_UA;
            PREDIV_BYPASS_O             <= 1'h1;
            DOUBLER_ACTIVE_O            <= 1'h0;
            PREDIV_RATIO_O              <= 6'h01;
            SECOND_STAGE_PUMP_CURRENT_O <= `PDCR_RST_PUMP2_CODE;
            OSC_OUTPUT_AMPLITUDE_O      <= 2'h0;
            OSC_OUTPUT_POWER_ON_O       <= 1'h0;
            OSC_OUTPUT_FORMAT_O         <= 1'h0;
            PHASE_OFFSET_ENABLE_O       <= 1'h0;
            PHASE_OFFSET_O              <= 5'h00;
        end else if (CE_I) begin
            SECOND_FB_DIVIDER_EN_O      <= ~second_fb_divider_powerdown_r;
            FB_CHAIN_PRODUCT_O          <= feedback_chain_select_r;
            LOCK_WINDOW_PHASE_O         <= {ref_divider_phase_r, fb_divider_phase_r};
            FIRST_STAGE_LOOP_EN_O       <= ~first_stage_bypass_r;
            FIRST_STAGE_ROUTE_AROUND_O  <= first_stage_bypass_r;
            OSC_TUNING_NEGATIVE_O       <= osc_tuning_polarity_r;
            TUNING_PIN_MID_O            <= force_mid_tuning_r;
            FIRST_STAGE_FORCE_UNLOCK_O  <= force_mid_tuning_r;
            FIRST_STAGE_PUMP_UA_O       <= pump_ua;
            PREDIV_BYPASS_O             <= pd_bypass;
            DOUBLER_ACTIVE_O            <= pd_double;
            PREDIV_RATIO_O              <= pd_ratio;
            SECOND_STAGE_PUMP_CURRENT_O <= second_stage_pump_current_r;
            OSC_OUTPUT_AMPLITUDE_O      <= osc_output_amplitude_r;
            OSC_OUTPUT_POWER_ON_O       <= osc_output_power_on_r;
            OSC_OUTPUT_FORMAT_O         <= osc_output_format_r;
            PHASE_OFFSET_ENABLE_O       <= phase_offset_enable_r;
            PHASE_OFFSET_O              <= phase_offset_r;
        end
    end

endmodule

// ---- bench/pdcr_regs_chk.sv ----
// Purpose: assertions on the divider control register bank
// Assumes: ports of pdcr_regs only, controls follow a write by two edges, predivider outputs by three
// Notes:   bound at the foot of this file
`timescale 1ns/1ps
`include "pdcr_defines.vh"
module pdcr_regs_chk (
    input wire        CLOCK_I,
    input wire        SYS_RST_I,
    input wire        CE_I,
    input wire [7:0]  ADDR_I,
    input wire [7:0]  WDATA_I,
    input wire        WR_I,
    input wire        SECOND_FB_DIVIDER_EN_O,
    input wire        FB_CHAIN_PRODUCT_O,
    input wire [5:0]  LOCK_WINDOW_PHASE_O,
    input wire        FIRST_STAGE_LOOP_EN_O,
    input wire        FIRST_STAGE_ROUTE_AROUND_O,
    input wire        OSC_TUNING_NEGATIVE_O,
    input wire        TUNING_PIN_MID_O,
    input wire        FIRST_STAGE_FORCE_UNLOCK_O,
    input wire [10:0] FIRST_STAGE_PUMP_UA_O,
    input wire        PREDIV_BYPASS_O,
    input wire        DOUBLER_ACTIVE_O,
    input wire [5:0]  PREDIV_RATIO_O
);
// ****************************************
// assertions
// ****************************************
default clocking @(posedge CLOCK_I); endclocking
default disable iff (SYS_RST_I);
pump_current_a:
assert property ((WR_I && CE_I && ADDR_I == `PDCR_ADDR_PUMP ##1 CE_I) |=> FIRST_STAGE_PUMP_UA_O ==
    ({6'h00, $past(WDATA_I[4:0], 2)} + 11'h001) * `PDCR_PUMP_STEP_UA) else $error("pump current wrong");
force_mid_a:
assert property ((WR_I && CE_I && ADDR_I == `PDCR_ADDR_PUMP ##1 CE_I) |=> TUNING_PIN_MID_O == $past(WDATA_I[6], 2)
    && FIRST_STAGE_FORCE_UNLOCK_O == TUNING_PIN_MID_O) else $error("force mid wrong");
tuning_polarity_a:
assert property ((WR_I && CE_I && ADDR_I == `PDCR_ADDR_PUMP ##1 CE_I) |=>
    OSC_TUNING_NEGATIVE_O == $past(WDATA_I[7], 2)) else $error("polarity wrong");
fb_powerdown_a:
assert property ((WR_I && CE_I && ADDR_I == `PDCR_ADDR_FB_BYPASS ##1 CE_I) |=>
    SECOND_FB_DIVIDER_EN_O == !$past(WDATA_I[7], 2)) else $error("divider enable wrong");
fb_chain_a:
assert property ((WR_I && CE_I && ADDR_I == `PDCR_ADDR_FB_BYPASS ##1 CE_I) |=>
    FB_CHAIN_PRODUCT_O == $past(WDATA_I[0], 2)) else $error("feedback chain wrong");
loop_route_a:
assert property ((WR_I && CE_I && ADDR_I == `PDCR_ADDR_FS_BYPASS ##1 CE_I) |=>
    FIRST_STAGE_ROUTE_AROUND_O == $past(WDATA_I[0], 2)
    && FIRST_STAGE_LOOP_EN_O != FIRST_STAGE_ROUTE_AROUND_O) else $error("loop bypass wrong");
ref_phase_a:
assert property ((WR_I && CE_I && ADDR_I == `PDCR_ADDR_REF_PHASE ##1 CE_I) |=>
    LOCK_WINDOW_PHASE_O[5:3] == $past(WDATA_I[2:0], 2)) else $error("phase window wrong");
fb_phase_a:
assert property ((WR_I && CE_I && ADDR_I == `PDCR_ADDR_FB_PHASE ##1 CE_I) |=>
    LOCK_WINDOW_PHASE_O[2:0] == $past(WDATA_I[2:0], 2)) else $error("feedback phase wrong");
doubler_path_a:
assert property ($rose(DOUBLER_ACTIVE_O) |-> ##[0:2] (PREDIV_BYPASS_O && PREDIV_RATIO_O == 6'h01))
    else $error("doubler path wrong");
doubler_select_a:
assert property ((WR_I && CE_I && ADDR_I == `PDCR_ADDR_PREDIV ##1 CE_I ##1 CE_I) |=>
    DOUBLER_ACTIVE_O == $past(WDATA_I[7], 3)) else $error("doubler select wrong");
prediv_ratio_a:
assert property ((WR_I && CE_I && ADDR_I == `PDCR_ADDR_PREDIV && !WDATA_I[7] && WDATA_I[5:0] != 6'h00
    ##1 CE_I ##1 CE_I) |=> !PREDIV_BYPASS_O && PREDIV_RATIO_O == $past(WDATA_I[5:0], 3))
    else $error("predivider ratio wrong");
prediv_zero_a:
assert property ((WR_I && CE_I && ADDR_I == `PDCR_ADDR_PREDIV && !WDATA_I[7] && WDATA_I[5:0] == 6'h00
    ##1 CE_I ##1 CE_I) |=> PREDIV_BYPASS_O && PREDIV_RATIO_O == 6'h01) else $error("predivider bypass wrong");
reset_values_a:
assert property ($fell(SYS_RST_I) |-> TUNING_PIN_MID_O && FIRST_STAGE_PUMP_UA_O == `PDCR_RST_PUMP_UA)
    else $error("reset value wrong");
cover property (WR_I && CE_I && ADDR_I == `PDCR_ADDR_PUMP);
cover property ($rose(DOUBLER_ACTIVE_O));
cover property ($rose(FIRST_STAGE_ROUTE_AROUND_O));
endmodule
bind pdcr_regs pdcr_regs_chk i_pdcr_regs_chk (.*);

// ---- bench/pdcr_regs_tb_top.sv ----
// Purpose: self-checking bench for the divider control register bank
// Assumes: controls settle within three edges of a write
// Notes:   one task per scenario
`timescale 1ns/1ps
module pdcr_regs_tb_top;
reg         clk = 1'b0;
reg         rst = 1'b1;
reg         ce = 1'b1;
reg         wr = 1'b0;
reg         rd = 1'b0;
reg  [7:0]  addr = 8'h00;
reg  [7:0]  wdata = 8'h00;
wire [7:0]  rdata;
wire        div_en, chain, loop_en, route, neg, mid, unlock, byp, dbl;
wire [5:0]  win, ratio;
wire [10:0] ua;
wire        pon, fmt, oen;
wire [4:0]  offs, pump2;
wire [1:0]  amp;
integer     mismatches = 0;
integer     n_tests = 0;
integer     cycles = 0;
pdcr_regs i_pdcr_regs (.CLOCK_I(clk), .SYS_RST_I(rst), .CE_I(ce), .ADDR_I(addr), .WDATA_I(wdata),
    .WR_I(wr), .RD_I(rd), .RDATA_O(rdata), .SECOND_FB_DIVIDER_EN_O(div_en), .FB_CHAIN_PRODUCT_O(chain),
    .LOCK_WINDOW_PHASE_O(win), .FIRST_STAGE_LOOP_EN_O(loop_en), .FIRST_STAGE_ROUTE_AROUND_O(route),
    .OSC_TUNING_NEGATIVE_O(neg), .TUNING_PIN_MID_O(mid), .FIRST_STAGE_FORCE_UNLOCK_O(unlock),
    .FIRST_STAGE_PUMP_UA_O(ua), .PREDIV_BYPASS_O(byp), .DOUBLER_ACTIVE_O(dbl), .PREDIV_RATIO_O(ratio),
    .SECOND_STAGE_PUMP_CURRENT_O(pump2), .OSC_OUTPUT_AMPLITUDE_O(amp), .OSC_OUTPUT_POWER_ON_O(pon),
    .OSC_OUTPUT_FORMAT_O(fmt), .PHASE_OFFSET_ENABLE_O(oen), .PHASE_OFFSET_O(offs));
// ****************************************
// tasks
// ****************************************
task cmp(input [10:0] got, input [10:0] exp);
    begin
        n_tests = n_tests + 1;
        if (got !== exp) begin
            mismatches = mismatches + 1;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    end
endtask
task cmp_rd(input [7:0] exp);
    begin
        n_tests = n_tests + 1;
        if (rdata !== exp) begin
            mismatches = mismatches + 1;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, rdata, exp);
        end
    end
endtask
task wr_reg(input [7:0] a, input [7:0] d);
    begin
        @(posedge clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
        repeat (3) @(posedge clk);
        #1;
    end
endtask
task rd_reg(input [7:0] a, input [7:0] exp);
    begin
        @(posedge clk);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        cmp_rd(exp);
    end
endtask
task conclude;
    begin
        $display("comparisons %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    end
endtask
// ****************************************
// scenarios
// ****************************************
task t_reset;
    begin
        cmp({mid, unlock, div_en, loop_en, route, byp}, 6'h3D);
        cmp(ua, 11'h4E2);
        rd_reg(8'h10, 8'h58);
        rd_reg(8'h11, 8'h00);
        rd_reg(8'h12, 8'h18);
        $display("reset done");
    end
endtask
task t_osc;
    begin
        wr_reg(8'h11, 8'hA5);
        cmp({pon, fmt, oen, offs}, 8'hA5);
        rd_reg(8'h11, 8'hA5);
        wr_reg(8'h12, 8'hFF);
        cmp({amp, pump2}, 7'h7F);
        rd_reg(8'h12, 8'h7F);
        $display("osc done");
    end
endtask
task t_pump;
    begin
        wr_reg(8'h10, 8'h80);
        cmp({neg, mid, unlock}, 3'h4);
        cmp(ua, 11'h032);
        wr_reg(8'h10, 8'hFF);
        cmp(ua, 11'h640);
        rd_reg(8'h10, 8'hDF);
        $display("pump done");
    end
endtask
task t_loop;
    begin
        wr_reg(8'h03, 8'hFF);
        cmp({div_en, chain}, 2'h1);
        rd_reg(8'h03, 8'h81);
        wr_reg(8'h03, 8'h00);
        cmp({div_en, chain}, 2'h2);
        wr_reg(8'h0A, 8'hFF);
        cmp({loop_en, route}, 2'h1);
        rd_reg(8'h0A, 8'h01);
        wr_reg(8'h05, 8'hFD);
        wr_reg(8'h06, 8'hFA);
        cmp(win, 6'h15);
        rd_reg(8'h06, 8'h02);
        $display("loop done");
    end
endtask
task t_prediv;
    begin
        wr_reg(8'h0C, 8'h3F);
        cmp({byp, dbl, ratio}, 8'h3F);
        wr_reg(8'h0C, 8'h00);
        cmp({byp, dbl, ratio}, 8'h81);
        wr_reg(8'h0C, 8'hFF);
        cmp({byp, dbl, ratio}, 8'hC1);
        rd_reg(8'h0C, 8'hBF);
        rd_reg(8'h13, 8'h0F);
        $display("prediv done");
    end
endtask
task t_misc;
    begin
        wr_reg(8'h7E, 8'hFF);
        rd_reg(8'h7E, 8'h00);
        @(posedge clk);
        ce <= 1'h0;
        wr_reg(8'h10, 8'h00);
        @(posedge clk);
        ce <= 1'h1;
        #1;
        cmp(ua, 11'h640);
        rd_reg(8'h10, 8'hDF);
        $display("misc done");
    end
endtask
task t_rerun;
    begin
        @(posedge clk);
        rst <= 1'h1;
        repeat (2) @(posedge clk);
        rst <= 1'h0;
        @(posedge clk);
        #1;
        cmp({mid, unlock, div_en, loop_en, route, byp}, 6'h3D);
        cmp(ua, 11'h4E2);
        rd_reg(8'h0C, 8'h00);
        rd_reg(8'h10, 8'h58);
        $display("rerun done");
    end
endtask
initial begin
    forever #4 clk = ~clk;
end
always @(posedge clk) begin
    cycles = cycles + 1;
    if (cycles == 2000) begin
        mismatches = mismatches + 1;
        conclude;
    end
end
initial begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    #1;
    t_reset;
    t_osc;
    t_pump;
    t_loop;
    t_prediv;
    t_misc;
    t_rerun;
    conclude;
end
endmodule
